// >>> bench/hfr_core_tb.sv
// Purpose: self-checking bench of the transponder response core
// Assumes: gap count shortened to GAP_P, clock enable high except in t_freeze
// Notes:   frames are decoded from the capacitor switch at each tick
`timescale 1ns/1ps
module hfr_core_tb;
	import hfr_pkg::*;
	localparam int GAP_P = 20;
	logic         clock_i;
	logic         sys_rst_i;
	logic         ce;
	logic         field_on;
	logic         tick;
	logic         mod_cap_en;
	logic         wr_en;
	logic [2:0]   wr_block;
	logic [32:0]  wr_data;
	logic         wr_done;
	logic         wr_refused;
	logic         cb_end;
	logic         tx_active;
	logic         dev_locked;
	logic [111:0] rx_frame;
	logic         bit_val;
	int           n_errors;
	int           cmp_count;
	int           cyc_count;
	int           bit_n;
	int           tick_n;

	hfr_core #(.GAP_CYCLES_P(GAP_P)) hfr_core_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
		.field_on_i(field_on), .resonant_terminal_tick_i(tick), .mod_cap_en_o(mod_cap_en),
		.wr_en_i(wr_en), .wr_block_i(wr_block), .wr_data_i(wr_data),
		.wr_done_o(wr_done), .wr_refused_o(wr_refused), .charge_burst_end_o(cb_end),
		.tx_active_o(tx_active), .dev_locked_o(dev_locked)
	);

	hfr_reader_model hfr_reader_model_i (
		.clock_i(clock_i), .mod_cap_en_i(mod_cap_en), .tx_active_i(tx_active),
		.field_on_o(field_on), .tick_o(tick)
	);

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc_count++;
		if (cyc_count == 80000) begin
			n_errors++;
			wrap_up();
		end
	end

	// one bit every 16 ticks; the switch must hold across the whole bit
	always @(posedge clock_i) begin
		if (tx_active && tick) begin
			// the first tick of an answer comes before any bit reaches the buffer head
			if (tick_n >= 0) begin
				if (tick_n % 16 == 0)
					bit_val = mod_cap_en;
				else if (mod_cap_en !== bit_val)
					check(mod_cap_en, bit_val);
				if (tick_n % 16 == 15) begin
					if (bit_n < 112)
						rx_frame[bit_n] = bit_val;
					bit_n++;
				end
			end
			tick_n++;
		end
	end

	function automatic logic [111:0] exp_frame(input logic [32:0] b1, input logic [32:0] b2);
		logic [63:0] id;
		logic [15:0] crc;
		logic        fb;
		id = {b2[32:1], b1[32:1]};
		crc = CRC_INIT;
		for (int i = 0; i < 64; i++) begin
			fb = crc[0] ^ id[i];
			crc = crc >> 1;
			if (fb)
				crc = crc ^ CRC_POLY_REV;
		end
		return {FRAME_TRL, crc, id, FRAME_HDR};
	endfunction

	task automatic wr(input logic [2:0] blk, input logic [32:0] d, input logic ok);
		@(posedge clock_i);
		#1 wr_en = 1'b1;
		wr_block = blk;
		wr_data = d;
		@(posedge clock_i);
		#1 wr_en = 1'b0;
		check({wr_done, wr_refused}, {ok, !ok});
	endtask

	task automatic t_writes();
		wr(3'h1, 33'h1_2345_678A, 1'b1);
		wr(3'h2, 33'h0_9ABC_DEF0, 1'b1);
		wr(3'h2, 33'h1_5A5A_C3C1, 1'b1);
		wr(3'h2, 33'h0_0000_0000, 1'b0);
		for (int b = 3; b < 7; b++)
			wr(3'(b), 33'h0_0000_0000, 1'b0);
		wr(3'h0, 33'h0_0000_0011, 1'b1);
		wr(3'h0, 33'h0_0000_0000, 1'b0);
		wr(3'h7, 33'h0_0000_0100, 1'b1);
		check(dev_locked, 1'b0);
	endtask

	task automatic t_read(input logic [32:0] b1, input logic [32:0] b2);
		int k;
		bit_n = 0;
		tick_n = -1;
		hfr_reader_model_i.set_field(1'b1);
		repeat (30) @(posedge clock_i);
		hfr_reader_model_i.set_field(1'b0);
		@(posedge clock_i);
		#1 check(cb_end, 1'b1);
		repeat (GAP_P + 1) @(posedge clock_i);
		#1 check(tx_active, 1'b0);
		@(posedge clock_i);
		#1 check(tx_active, 1'b1);
		wr(3'h1, 33'h0_FFFF_0000, 1'b0);
		k = 0;
		while (tx_active && k < 40000) begin
			@(posedge clock_i);
			#1 k++;
		end
		check(bit_n, 112);
		check(rx_frame, exp_frame(b1, b2));
		@(posedge clock_i);
		#1 check(mod_cap_en, 1'b0);
	endtask

	// field returns before the gap runs out: no answer
	task automatic t_abort();
		logic seen;
		seen = 1'b0;
		hfr_reader_model_i.set_field(1'b1);
		repeat (10) @(posedge clock_i);
		hfr_reader_model_i.set_field(1'b0);
		repeat (GAP_P - 1) @(posedge clock_i);
		hfr_reader_model_i.set_field(1'b1);
		repeat (GAP_P + 10) begin
			@(posedge clock_i);
			#1 seen = seen | tx_active;
		end
		check(seen, 1'b0);
	endtask

	task automatic t_dev_lock();
		wr(3'h7, 33'h0_0000_0002, 1'b1);
		check(dev_locked, 1'b1);
		wr(3'h1, 33'h0_0000_0000, 1'b0);
	endtask

	// a write held while the enable is low must not be taken
	task automatic t_freeze();
		@(posedge clock_i);
		#1 ce = 1'b0;
		wr_en = 1'b1;
		wr_block = 3'h7;
		wr_data = 33'h0_0000_0002;
		repeat (3) @(posedge clock_i);
		#1 wr_en = 1'b0;
		ce = 1'b1;
		check({wr_done, wr_refused, dev_locked}, 3'h0);
	endtask

	// reset in mid-run clears the device lock and accepts writes again
	task automatic t_reset();
		@(posedge clock_i);
		#1 sys_rst_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1 sys_rst_i = 1'b0;
		check({dev_locked, wr_done, wr_refused}, 3'h0);
		wr(3'h7, 33'h0_0000_0000, 1'b1);
	endtask

	initial begin
		sys_rst_i = 1'b1;
		ce = 1'b1;
		wr_en = 1'b0;
		wr_block = 3'h0;
		wr_data = 33'h0_0000_0000;
		rx_frame = '0;
		bit_val = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		cyc_count = 0;
		bit_n = 0;
		tick_n = 0;
		repeat (20) @(posedge clock_i);
		#1 check({mod_cap_en, wr_done, wr_refused, cb_end, tx_active, dev_locked}, 6'h00);
		sys_rst_i = 1'b0;
		t_writes();
		t_freeze();
		t_read(33'h1_2345_678A, 33'h1_5A5A_C3C1);
		t_abort();
		t_read(33'h1_2345_678A, 33'h1_5A5A_C3C1);
		t_dev_lock();
		t_reset();
		wrap_up();
	end
endmodule

// >>> bench/hfr_reader_model.sv
// Purpose: reader and tank model for the response core
// Assumes: carrier and tank ticks scaled to a few core cycles
// Notes:   the tank rings slower while the modulation capacitor is in
`timescale 1ns/1ps
module hfr_reader_model (
	// clock
	input  wire logic clock_i,
	// air side
	input  wire logic mod_cap_en_i,
	input  wire logic tx_active_i,
	output logic      field_on_o,
	output logic      tick_o
);
	logic [3:0] div_reg;

	initial begin
		field_on_o = 1'b0;
		tick_o = 1'b0;
		div_reg = 4'h0;
	end

	// never powers up while the tag answers
	task automatic set_field(input logic v);
		while (v && tx_active_i) @(posedge clock_i);
		@(posedge clock_i);
		#1 field_on_o = v;
	endtask

	// ticks stand still unless the tank rings
	always @(posedge clock_i) begin
		#1;
		if (!(field_on_o || tx_active_i)) begin
			div_reg = 4'h0;
			tick_o = 1'b0;
		end else begin
			tick_o = (div_reg == 4'h0);
			div_reg = (div_reg >= (mod_cap_en_i ? 4'h8 : 4'h7)) ? 4'h0 : div_reg + 4'h1;
		end
	end
endmodule

// >>> core/hfr_core.sv
// Purpose: response side of a half-duplex low frequency transponder
// Assumes: field and oscillation ticks arrive synchronous to clock_i
// Notes:   request decoding is outside; writes arrive already decoded
// Behaviour
// - four nonvolatile 33-bit blocks
// - bits 1 to 32 hold payload
// - bit 0 locks its block against writes
// - blocks 1 and 2 form ID page
// - blocks 0 and 7 configure, incl device lock
// - reverse CCITT checksum computed on chip
// - response starts once the field stays off past the gap after charge burst end
// - one at lower frequency, zero at carrier
// - each bit lasts 16 own oscillations
// - bits coded NRZ, frequency held whole bit
// - field off over 40 periods: send ID
// - every response frame is 112 bits
`timescale 1ns/1ps
module hfr_core #(
	parameter int GAP_CYCLES_P = hfr_pkg::GAP_CYCLES
) (
	// clock, reset, enable
	input  wire logic                       clock_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       ce_i,
	// analog front end
	input  wire logic                       field_on_i,
	input  wire logic                       resonant_terminal_tick_i,
	output logic                            mod_cap_en_o,
	// decoded block write
	input  wire logic                       wr_en_i,
	input  wire logic [2:0]                 wr_block_i,
	input  wire logic [hfr_pkg::BLK_WIDTH-1:0] wr_data_i,
	output logic                            wr_done_o,
	output logic                            wr_refused_o,
	// status
	output logic                            charge_burst_end_o,
	output logic                            tx_active_o,
	output logic                            dev_locked_o
);
	import hfr_pkg::*;

	// maps a block number onto a storage slot; bit 2 of result flags a valid block
	function automatic logic [2:0] blk_slot(input logic [2:0] num);
		case (num)
			BLK_NUM_CFG0: blk_slot = {1'b1, SLOT_CFG0};
			BLK_NUM_IDLO: blk_slot = {1'b1, SLOT_IDLO};
			BLK_NUM_IDHI: blk_slot = {1'b1, SLOT_IDHI};
			BLK_NUM_CFG7: blk_slot = {1'b1, SLOT_CFG7};
			default:      blk_slot = 3'h0;
		endcase
	endfunction

	// serial reflected CCITT over the page, LSB first as it is sent
	function automatic logic [15:0] crc_rev(input logic [63:0] page);
		logic [15:0] c;
		c = CRC_INIT;
		for (int i = 0; i < 64; i++) begin
			if (c[0] ^ page[i]) begin
				c = (c >> 1) ^ CRC_POLY_REV;
			end else begin
				c = c >> 1;
			end
		end
		crc_rev = c;
	endfunction

	hfr_state_t            state_reg;
	logic [BLK_WIDTH-1:0]  blk_reg [BLK_COUNT];
	logic [19:0]           gap_cnt_reg;
	logic [FRAME_BITS-1:0] frame_reg;
	logic [6:0]            push_idx_reg;
	logic [6:0]            sent_cnt_reg;
	logic [3:0]            osc_cnt_reg;
	logic [2:0]            wr_slot;
	logic                  wr_ok;
	logic                  wr_req;
	logic                  gap_over;
	logic                  drain_pop;
	logic [63:0]           id_page;

	hfr_stream_if #(.WIDTH(FIFO_WIDTH)) fill_s ();
	hfr_stream_if #(.WIDTH(FIFO_WIDTH)) drain_s ();

	hfr_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.fill_s    (fill_s),
		.drain_s   (drain_s)
	);

	assign id_page      = {blk_reg[SLOT_IDHI][PAYLOAD_MSB:PAYLOAD_LSB],
			blk_reg[SLOT_IDLO][PAYLOAD_MSB:PAYLOAD_LSB]};
	assign dev_locked_o = blk_reg[SLOT_CFG7][DEV_LOCK_POS];
	assign tx_active_o  = state_reg == ST_SEND;
	assign gap_over     = gap_cnt_reg > GAP_CYCLES_P[19:0];

	// writes
	assign wr_slot = blk_slot(wr_block_i);
	assign wr_req  = ce_i && wr_en_i;
	// no write while answering: the stored energy is reserved for the response
	assign wr_ok   = wr_slot[2] && !blk_reg[wr_slot[1:0]][LOCK_POS] && !dev_locked_o
			&& state_reg != ST_SEND;

	// nonvolatile content has no real reset; cleared here only for a defined start
	generate
		for (genvar g = 0; g < BLK_COUNT; g++) begin : g_blk
			always_ff @(posedge clock_i) begin
				if (sys_rst_i) begin
					blk_reg[g] <= BLK_RESET;
				end else if (wr_req && wr_ok && wr_slot[1:0] == 2'(g)) begin
					blk_reg[g] <= wr_data_i;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_done_o    <= 1'b0;
			wr_refused_o <= 1'b0;
		end else if (ce_i) begin
			wr_done_o    <= wr_en_i && wr_ok;
			wr_refused_o <= wr_en_i && !wr_ok;
		end
	end

	// exchange sequencing
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
		end else if (ce_i) begin
			case (state_reg)
				ST_IDLE: begin
					if (field_on_i) begin
						state_reg <= ST_CHARGE;
					end
				end
				ST_CHARGE: begin
					if (!field_on_i) begin
						state_reg <= ST_GAP;
					end
				end
				ST_GAP: begin
					// field back within the gap means a reader request is starting
					if (field_on_i) begin
						state_reg <= ST_CHARGE;
					end else if (gap_over) begin
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (sent_cnt_reg == 7'(FRAME_BITS)) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			charge_burst_end_o <= 1'b0;
		end else if (ce_i) begin
			charge_burst_end_o <= state_reg == ST_CHARGE && !field_on_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			gap_cnt_reg <= '0;
		end else if (ce_i) begin
			if (state_reg == ST_GAP && !field_on_i) begin
				gap_cnt_reg <= gap_cnt_reg + 1'b1;
			end else begin
				gap_cnt_reg <= '0;
			end
		end
	end

	// frame built once as the answer starts
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			frame_reg <= '0;
		end else if (ce_i && state_reg == ST_GAP && !field_on_i && gap_over) begin
			frame_reg <= {FRAME_TRL, crc_rev(id_page), id_page, FRAME_HDR};
		end
	end

	// producer: stalls on a full buffer
	assign fill_s.valid = state_reg == ST_SEND && push_idx_reg < 7'(FRAME_BITS);
	assign fill_s.data  = frame_reg[push_idx_reg];

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			push_idx_reg <= '0;
		end else if (ce_i) begin
			if (state_reg != ST_SEND) begin
				push_idx_reg <= '0;
			end else if (fill_s.valid && fill_s.ready) begin
				push_idx_reg <= push_idx_reg + 1'b1;
			end
		end
	end

	// sender: one bit per 16 oscillations of the tank
	assign drain_pop     = state_reg == ST_SEND && drain_s.valid && resonant_terminal_tick_i
			&& osc_cnt_reg == 4'(BIT_OSC_CYCLES - 1);
	assign drain_s.ready = drain_pop;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			osc_cnt_reg  <= '0;
			sent_cnt_reg <= '0;
		end else if (ce_i) begin
			if (state_reg != ST_SEND) begin
				osc_cnt_reg  <= '0;
				sent_cnt_reg <= '0;
			end else if (drain_s.valid && resonant_terminal_tick_i) begin
				osc_cnt_reg <= osc_cnt_reg + 1'b1;
				if (drain_pop) begin
					sent_cnt_reg <= sent_cnt_reg + 1'b1;
				end
			end
		end
	end

	// capacitor tracks the head bit, held until that bit is popped
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			mod_cap_en_o <= 1'b0;
		end else if (ce_i) begin
			mod_cap_en_o <= state_reg == ST_SEND && drain_s.valid && drain_s.data[0];
		end
	end

	a_lock_blocks_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_req && wr_slot[2] && blk_reg[wr_slot[1:0]][LOCK_POS] |=> wr_refused_o && !wr_done_o)
		else $error("write to a locked block was accepted");

	a_dev_lock_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_req && dev_locked_o |=> wr_refused_o && $stable(dev_locked_o))
		else $error("write accepted while device locked");

	a_write_stores: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_req && wr_ok && wr_slot[1:0] == SLOT_IDLO |=> id_page[31:0] == $past(wr_data_i[32:1]))
		else $error("payload not stored in bits 1 to 32");

	a_gap_then_send: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg == ST_GAP && !field_on_i && gap_over
		|=> state_reg == ST_SEND && frame_reg[CRC_POS +: 16] == crc_rev(id_page))
		else $error("gap expiry did not start the ID answer");

	a_field_cancels_gap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg == ST_GAP && field_on_i |=> state_reg == ST_CHARGE)
		else $error("field return did not cancel the answer");

	a_burst_end_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg == ST_CHARGE && !field_on_i |=> charge_burst_end_o && state_reg == ST_GAP)
		else $error("charge burst end not flagged");

	// every tank tick inside a bit must advance the count, so a pop at 15 means 16 ticks
	a_bit_length: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && tx_active_o && drain_s.valid && resonant_terminal_tick_i
		|=> osc_cnt_reg == 4'($past(osc_cnt_reg) + 4'h1))
		else $error("tank tick not counted inside a bit");

	a_nrz_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg == ST_SEND && drain_s.valid && !drain_pop ##1 ce_i && state_reg == ST_SEND
		|=> $stable(mod_cap_en_o))
		else $error("modulation changed inside a bit");

	a_frame_length: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg == ST_SEND && sent_cnt_reg == 7'(FRAME_BITS) |=> state_reg == ST_IDLE
		&& !mod_cap_en_o)
		else $error("frame did not end after 112 bits");

	a_cap_off_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ce_i && state_reg != ST_SEND |=> !mod_cap_en_o)
		else $error("capacitor switched outside an answer");
endmodule

// >>> core/hfr_fifo.sv
// Purpose: flip-flop FIFO of response bits
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from pointers with one wrap bit
`timescale 1ns/1ps
module hfr_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// clock and control
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	input  wire logic ce_i,
	// streams
	hfr_stream_if.snk fill_s,
	hfr_stream_if.src drain_s
);
	import hfr_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign full          = (wr_ptr_reg ^ rd_ptr_reg) == {1'b1, {AW{1'b0}}};
	assign empty         = wr_ptr_reg == rd_ptr_reg;
	assign fill_s.ready  = !full;
	assign drain_s.valid = !empty;
	assign drain_s.data  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push          = ce_i && fill_s.valid && !full;
	assign pop           = ce_i && drain_s.ready && !empty;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= fill_s.data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

	a_fifo_full_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		full && !pop |=> $stable(wr_ptr_reg))
		else $error("fifo pointer moved while full");
endmodule

// >>> core/hfr_pkg.sv
// Purpose: shared constants and types of the transponder response core
// Assumes: 200 MHz core clock, carrier period counted in core cycles
// Notes:   block numbers 0, 1, 2 and 7 map onto storage slots 0..3
package hfr_pkg;
	// memory organisation
	localparam int              BLK_COUNT    = 4;
	localparam int              BLK_WIDTH    = 33;
	localparam int              LOCK_POS     = 0;
	localparam int              PAYLOAD_LSB  = 1;
	localparam int              PAYLOAD_MSB  = 32;
	localparam logic [2:0]      BLK_NUM_CFG0 = 3'h0;
	localparam logic [2:0]      BLK_NUM_IDLO = 3'h1;
	localparam logic [2:0]      BLK_NUM_IDHI = 3'h2;
	localparam logic [2:0]      BLK_NUM_CFG7 = 3'h7;
	localparam logic [1:0]      SLOT_CFG0    = 2'h0;
	localparam logic [1:0]      SLOT_IDLO    = 2'h1;
	localparam logic [1:0]      SLOT_IDHI    = 2'h2;
	localparam logic [1:0]      SLOT_CFG7    = 2'h3;
	localparam logic [32:0]     BLK_RESET    = 33'h0_0000_0000;
	// device-wide lock flag inside the block 7 configuration word
	localparam int              DEV_LOCK_POS = 1;

	// response frame layout, transmitted index 0 first
	localparam int              FRAME_BITS   = 112;
	localparam int              HDR_POS      = 0;
	localparam int              ID_POS       = 8;
	localparam int              CRC_POS      = 72;
	localparam int              TRL_POS      = 88;
	localparam logic [7:0]      FRAME_HDR    = 8'h7E;
	localparam logic [23:0]     FRAME_TRL    = 24'h00_0000;
	localparam logic [15:0]     CRC_POLY_REV = 16'h8408;
	localparam logic [15:0]     CRC_INIT     = 16'h0000;

	// timing
	localparam int              BIT_OSC_CYCLES = 16;
	localparam int              CLK_PERIOD_PS  = 5000;
	localparam int              CARRIER_PS     = 7452000;
	localparam int              GAP_PERIODS    = 40;
	localparam int              GAP_CYCLES     = (GAP_PERIODS * CARRIER_PS) / CLK_PERIOD_PS;

	// buffering
	localparam int              FIFO_WIDTH   = 1;
	localparam int              FIFO_DEPTH   = 16;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_CHARGE = 2'b01,
		ST_GAP    = 2'b10,
		ST_SEND   = 2'b11
	} hfr_state_t;
endpackage

// >>> core/hfr_stream_if.sv
// Purpose: valid/ready stream between the frame builder, buffer and bit sender
// Assumes: data is held stable while valid is high and ready is low
// Notes:   one transfer per clock where valid and ready are both high
`timescale 1ns/1ps
interface hfr_stream_if #(parameter int WIDTH = 1);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
